// ### hdl/tpo_timed_pattern.sv
// Register core of a 16-pin timed pattern output controller.
// Assumes timer compare-match strobes and standby come from
// logic on sys_clk; the register master follows the plain port.
//
// Notes on behaviour
// [RULE1] Selected trigger copies enabled high buffer bits
// [RULE2] High buffer cleared by reset, hardware standby
// [RULE3] Shared trigger: high buffer whole at first
// [RULE4] Shared trigger: alternate byte reads ones, read-only
// [RULE5] Split: group 3 first, group 2 alternate
// [RULE6] Split: unused nibbles read ones, unwritable
// [RULE7] Split low: first address holds group 1
// [RULE8] Enabled low bits copied on group trigger
// [RULE9] Disabled bits never copied, output unchanged
// [RULE10] High enables gate each high bit separately
// [RULE11] Low enable bit n controls pin n
// [RULE12] Enables cleared by reset, hardware standby
// [RULE13] Trigger select resets to all ones
// [RULE14] Two-bit code picks timer channel number
// [RULE15] Bits 7:6 select group 3 trigger
// [RULE16] Bits 5:4 select group 2 trigger
// [RULE17] Bits 3:2 select group 1 trigger
// [RULE18] Bits 1:0 select group 0 trigger
// [RULE19] Enabled latch bits read-only, still copied
// [RULE20] Pin drives when direction and enable set
// [RULE21] Transfer next cycle, same-cycle write later
// [RULE22] Timer gives one-cycle strobes per channel
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module tpo_timed_pattern (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hw_standby,
  input wire logic [tpo_pkg::ADDR_W-1:0] addr,
  input wire logic [tpo_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [tpo_pkg::DATA_W-1:0] rdata,
  input wire logic [tpo_pkg::N_CH-1:0] cm_strobe,
  output logic [tpo_pkg::PIN_W-1:0] pattern_pins,
  output logic [tpo_pkg::PIN_W-1:0] pattern_pins_oe
);
  import tpo_pkg::*;

  logic [7:0] next_pattern_high;
  logic [7:0] next_pattern_low;
  logic [7:0] transfer_enable_high;
  logic [7:0] transfer_enable_low;
  logic [7:0] group_trigger_select;
  logic [7:0] port_latch_high;
  logic [7:0] port_latch_low;
  logic [7:0] pin_direction_high;
  logic [7:0] pin_direction_low;
  logic [7:0] next_port_latch_high;
  logic [7:0] next_port_latch_low;
  logic [N_GRP-1:0] grp_fire;
  logic [PIN_W-1:0] fire_bit;
  logic [7:0] xfer_high;
  logic [7:0] xfer_low;
  logic shared_high;
  logic shared_low;
  logic run;

  // Standby counts as a clear only while the clock is enabled
  assign run = ce && !hw_standby;

  // [RULE15] [RULE16] group trigger pairing
  assign shared_high = group_trigger_select[SEL_G3_LSB +: SEL_W] ==
                       group_trigger_select[SEL_G2_LSB +: SEL_W];
  // [RULE17] [RULE18] group trigger pairing
  assign shared_low = group_trigger_select[SEL_G1_LSB +: SEL_W] ==
                      group_trigger_select[SEL_G0_LSB +: SEL_W];

  // [RULE14] code selects channel
  genvar g;
  generate
    for (g = 0; g < N_GRP; g++) begin : grp
      assign grp_fire[g] = cm_strobe[group_trigger_select[g*SEL_W +: SEL_W]];
      assign fire_bit[g*GRP_W +: GRP_W] = {GRP_W{grp_fire[g]}};
    end
  endgenerate

  // [RULE10] [RULE11] per-bit gating
  assign xfer_high = fire_bit[15:8] & transfer_enable_high;
  assign xfer_low = fire_bit[7:0] & transfer_enable_low;

  // Standby clear beats a write in the same cycle
  // [RULE2] [RULE3] [RULE5] high buffer writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      next_pattern_high <= NP_RST;
    end else if (ce) begin
      if (hw_standby) begin
        next_pattern_high <= NP_RST;
      end else if (wr && addr == ADR_NP_HIGH) begin
        if (shared_high) begin
          next_pattern_high <= wdata;
        end else begin
          next_pattern_high[7:4] <= wdata[7:4];
        end
      end else if (wr && addr == ADR_NP_HIGH_ALT && !shared_high) begin
        next_pattern_high[3:0] <= wdata[3:0];
      end
    end
  end

  // [RULE7] low buffer writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      next_pattern_low <= NP_RST;
    end else if (ce) begin
      if (hw_standby) begin
        next_pattern_low <= NP_RST;
      end else if (wr && addr == ADR_NP_LOW) begin
        if (shared_low) begin
          next_pattern_low <= wdata;
        end else begin
          next_pattern_low[7:4] <= wdata[7:4];
        end
      end else if (wr && addr == ADR_NP_LOW_ALT && !shared_low) begin
        next_pattern_low[3:0] <= wdata[3:0];
      end
    end
  end

  // [RULE12] enables reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_enable_high <= TE_RST;
      transfer_enable_low <= TE_RST;
    end else if (ce) begin
      if (hw_standby) begin
        transfer_enable_high <= TE_RST;
        transfer_enable_low <= TE_RST;
      end else if (wr && addr == ADR_TE_HIGH) begin
        transfer_enable_high <= wdata;
      end else if (wr && addr == ADR_TE_LOW) begin
        transfer_enable_low <= wdata;
      end
    end
  end

  // [RULE13] select resets to ones
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      group_trigger_select <= TRIG_RST;
    end else if (ce) begin
      if (hw_standby) begin
        group_trigger_select <= TRIG_RST;
      end else if (wr && addr == ADR_TRIG_SEL) begin
        group_trigger_select <= wdata;
      end
    end
  end

  // Directions kept here to form the pin enables and for read-back
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_direction_high <= DIR_RST;
      pin_direction_low <= DIR_RST;
    end else if (ce) begin
      if (hw_standby) begin
        pin_direction_high <= DIR_RST;
        pin_direction_low <= DIR_RST;
      end else if (wr && addr == ADR_DIR_HIGH) begin
        pin_direction_high <= wdata;
      end else if (wr && addr == ADR_DIR_LOW) begin
        pin_direction_low <= wdata;
      end
    end
  end

  // Trigger applied after the write, so it wins on enabled bits
  // [RULE19] enabled bits ignore writes
  // [RULE1] [RULE8] [RULE9] copy only enabled
  always_comb begin
    next_port_latch_high = port_latch_high;
    next_port_latch_low = port_latch_low;
    if (wr && addr == ADR_LATCH_HIGH) begin
      next_port_latch_high = (wdata & ~transfer_enable_high) |
                             (port_latch_high & transfer_enable_high);
    end
    if (wr && addr == ADR_LATCH_LOW) begin
      next_port_latch_low = (wdata & ~transfer_enable_low) |
                            (port_latch_low & transfer_enable_low);
    end
    next_port_latch_high = (next_port_latch_high & ~xfer_high) |
                           (next_pattern_high & xfer_high);
    next_port_latch_low = (next_port_latch_low & ~xfer_low) |
                          (next_pattern_low & xfer_low);
  end

  // [RULE21] buffer sampled before same-cycle write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_latch_high <= LATCH_RST;
      port_latch_low <= LATCH_RST;
    end else if (ce) begin
      if (hw_standby) begin
        port_latch_high <= LATCH_RST;
        port_latch_low <= LATCH_RST;
      end else begin
        port_latch_high <= next_port_latch_high;
        port_latch_low <= next_port_latch_low;
      end
    end
  end

  // Pins show the latch itself, no extra stage to skew them
  assign pattern_pins = {port_latch_high, port_latch_low};

  // [RULE20] drive only when both set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pattern_pins_oe <= '0;
    end else if (ce) begin
      pattern_pins_oe <= {pin_direction_high & transfer_enable_high,
                          pin_direction_low & transfer_enable_low};
    end
  end

  // Read data holds until the next read; unmapped bytes read zero
  // [RULE4] [RULE6] reserved bits read ones
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= UNMAPPED_RD;
    end else if (ce && rd) begin
      unique case (addr)
        ADR_NP_HIGH: rdata <= shared_high ? next_pattern_high :
                              {next_pattern_high[7:4], RSV_NIB};
        ADR_NP_HIGH_ALT: rdata <= shared_high ? RSV_BYTE :
                                  {RSV_NIB, next_pattern_high[3:0]};
        ADR_NP_LOW: rdata <= shared_low ? next_pattern_low :
                             {next_pattern_low[7:4], RSV_NIB};
        ADR_NP_LOW_ALT: rdata <= shared_low ? RSV_BYTE :
                                 {RSV_NIB, next_pattern_low[3:0]};
        ADR_TE_HIGH: rdata <= transfer_enable_high;
        ADR_TE_LOW: rdata <= transfer_enable_low;
        ADR_TRIG_SEL: rdata <= group_trigger_select;
        ADR_LATCH_HIGH: rdata <= port_latch_high;
        ADR_LATCH_LOW: rdata <= port_latch_low;
        ADR_DIR_HIGH: rdata <= pin_direction_high;
        ADR_DIR_LOW: rdata <= pin_direction_low;
        default: rdata <= UNMAPPED_RD;
      endcase
    end
  end

  // Checks below rely on the timer keeping strobes one cycle wide
  // [RULE22] relied on here

  high_copy_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE1]
    run |=> ((port_latch_high ^ $past(next_pattern_high)) & $past(xfer_high)) == 8'h00)
    else $error("high latch missed enabled copy");

  low_copy_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    run |=> ((port_latch_low ^ $past(next_pattern_low)) & $past(xfer_low)) == 8'h00)
    else $error("low latch missed enabled copy");

  disabled_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE9]
    run && !(wr && addr == ADR_LATCH_HIGH) |=>
      ((port_latch_high ^ $past(port_latch_high)) & ~$past(xfer_high)) == 8'h00)
    else $error("high latch changed without transfer");

  latch_ro_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE19]
    run && wr && addr == ADR_LATCH_LOW |=>
      ((port_latch_low ^ $past(port_latch_low)) &
       $past(transfer_enable_low & ~xfer_low)) == 8'h00)
    else $error("enabled latch bit took software write");

  standby_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    ce && hw_standby |=> next_pattern_high == NP_RST && transfer_enable_low == TE_RST &&
      transfer_enable_high == TE_RST && group_trigger_select == TRIG_RST)
    else $error("hardware standby did not initialise");

  shared_alt_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
    ce && rd && addr == ADR_NP_HIGH_ALT && shared_high |=> rdata == RSV_BYTE)
    else $error("shared alternate byte not all ones");

  split_first_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
    ce && rd && addr == ADR_NP_HIGH && !shared_high |=>
      rdata == {$past(next_pattern_high[7:4]), RSV_NIB})
    else $error("split first address read wrong");

  low_split_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE7]
    ce && rd && addr == ADR_NP_LOW && !shared_low |=> rdata[3:0] == RSV_NIB)
    else $error("split low reserved nibble not ones");

  alt_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE5]
    run && wr && addr == ADR_NP_HIGH_ALT && !shared_high |=>
      next_pattern_high == {$past(next_pattern_high[7:4]), $past(wdata[3:0])})
    else $error("split alternate write misplaced");

  chan3_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
    run && cm_strobe == 4'h8 && group_trigger_select == TRIG_RST &&
      transfer_enable_high == 8'hFF |=> port_latch_high == $past(next_pattern_high))
    else $error("channel 3 trigger failed to copy");

  pin_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE20]
    ce |=> pattern_pins_oe == $past({pin_direction_high & transfer_enable_high,
                                    pin_direction_low & transfer_enable_low}))
    else $error("pin enable not direction and enable");

  shared_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    run && wr && addr == ADR_NP_HIGH && shared_high |=> next_pattern_high == $past(wdata))
    else $error("shared buffer write not whole byte");

  shared_alt_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
    run && wr && addr == ADR_NP_HIGH_ALT && shared_high |=>
      next_pattern_high == $past(next_pattern_high))
    else $error("shared alternate write reached buffer");

  split_first_wr_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE5]
    run && wr && addr == ADR_NP_HIGH && !shared_high |=>
      next_pattern_high == {$past(wdata[7:4]), $past(next_pattern_high[3:0])})
    else $error("split first write touched lower nibble");

  split_alt_rd_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
    ce && rd && addr == ADR_NP_HIGH_ALT && !shared_high |=>
      rdata == {RSV_NIB, $past(next_pattern_high[3:0])})
    else $error("split alternate read wrong");

  high_ro_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    run && wr && addr == ADR_LATCH_HIGH |=>
      ((port_latch_high ^ $past(port_latch_high)) &
       $past(transfer_enable_high & ~xfer_high)) == 8'h00)
    else $error("enabled high latch bit took write");

  low_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE11]
    run && !(wr && addr == ADR_LATCH_LOW) |=>
      ((port_latch_low ^ $past(port_latch_low)) & ~$past(xfer_low)) == 8'h00)
    else $error("low latch changed without transfer");

  no_trigger_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
    run && cm_strobe == 4'h0 && !(wr && addr == ADR_LATCH_HIGH) |=>
      port_latch_high == $past(port_latch_high))
    else $error("high latch moved with no strobe");

  grp3_pick_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE15]
    run && cm_strobe == (4'h1 << group_trigger_select[SEL_G3_LSB +: SEL_W]) |=>
      ((port_latch_high[GRP_W +: GRP_W] ^ $past(next_pattern_high[GRP_W +: GRP_W])) &
       $past(transfer_enable_high[GRP_W +: GRP_W])) == 4'h0)
    else $error("group 3 ignored its channel");

  grp2_pick_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE16]
    run && cm_strobe == (4'h1 << group_trigger_select[SEL_G2_LSB +: SEL_W]) |=>
      ((port_latch_high[0 +: GRP_W] ^ $past(next_pattern_high[0 +: GRP_W])) &
       $past(transfer_enable_high[0 +: GRP_W])) == 4'h0)
    else $error("group 2 ignored its channel");

  grp1_pick_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE17]
    run && cm_strobe == (4'h1 << group_trigger_select[SEL_G1_LSB +: SEL_W]) |=>
      ((port_latch_low[GRP_W +: GRP_W] ^ $past(next_pattern_low[GRP_W +: GRP_W])) &
       $past(transfer_enable_low[GRP_W +: GRP_W])) == 4'h0)
    else $error("group 1 ignored its channel");

  grp0_pick_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE18]
    run && cm_strobe == (4'h1 << group_trigger_select[SEL_G0_LSB +: SEL_W]) |=>
      ((port_latch_low[0 +: GRP_W] ^ $past(next_pattern_low[0 +: GRP_W])) &
       $past(transfer_enable_low[0 +: GRP_W])) == 4'h0)
    else $error("group 0 ignored its channel");

  buffer_freeze_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2]
    !ce |=> $stable(next_pattern_high) && $stable(next_pattern_low) &&
      $stable(port_latch_high) && $stable(port_latch_low))
    else $error("buffer or latch moved while frozen");

  enable_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    !ce |=> $stable(transfer_enable_high) && $stable(transfer_enable_low))
    else $error("enables moved while frozen");

  select_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE13]
    !ce |=> $stable(group_trigger_select))
    else $error("trigger select moved while frozen");

  same_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE21]
    run && wr && addr == ADR_NP_HIGH && xfer_high != 8'h00 |=>
      ((port_latch_high ^ $past(next_pattern_high)) & $past(xfer_high)) == 8'h00)
    else $error("same-cycle buffer write leaked to latch");
endmodule

// ### hdl/tpo_pkg.sv
// Constants for the timed pattern output register core.
// Assumes a byte-wide register port with a 16-bit address.
package tpo_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int N_GRP = 4;
  localparam int N_CH = 4;
  localparam int GRP_W = 4;
  localparam int SEL_W = 2;
  localparam int PIN_W = 16;

  // Next-pattern buffers, both address layouts
  localparam logic [15:0] ADR_NP_HIGH = 16'hFFA4;
  localparam logic [15:0] ADR_NP_LOW = 16'hFFA5;
  localparam logic [15:0] ADR_NP_HIGH_ALT = 16'hFFA6;
  localparam logic [15:0] ADR_NP_LOW_ALT = 16'hFFA7;
  // Control and port registers
  localparam logic [15:0] ADR_TE_HIGH = 16'hFFA0;
  localparam logic [15:0] ADR_TE_LOW = 16'hFFA1;
  localparam logic [15:0] ADR_TRIG_SEL = 16'hFFA2;
  localparam logic [15:0] ADR_LATCH_LOW = 16'hFFA8;
  localparam logic [15:0] ADR_LATCH_HIGH = 16'hFFA9;
  localparam logic [15:0] ADR_DIR_LOW = 16'hFFAA;
  localparam logic [15:0] ADR_DIR_HIGH = 16'hFFAB;

  localparam logic [7:0] NP_RST = 8'h00;
  localparam logic [7:0] TE_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'hFF;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] RSV_BYTE = 8'hFF;
  localparam logic [3:0] RSV_NIB = 4'hF;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Trigger-select fields per group
  localparam int SEL_G3_LSB = 6;
  localparam int SEL_G2_LSB = 4;
  localparam int SEL_G1_LSB = 2;
  localparam int SEL_G0_LSB = 0;
endpackage

// ### tb/tpo_timer_model.sv
// Timer unit stand-in giving compare-match strobes on command.
// Assumes the bench raises req for one cycle per wanted event.
`timescale 1ns/1ps
module tpo_timer_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] req,
  output logic [3:0] cm_strobe
);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cm_strobe <= 4'h0;
    end else begin
      cm_strobe <= req;
    end
  end
endmodule

// ### tb/timed_pattern_output_regs_tb.sv
// Self-checking bench for the timed pattern output register core.
// Assumes tpo_timer_model as the source of compare-match strobes.
`timescale 1ns/1ps
module timed_pattern_output_regs_tb;
  import tpo_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic hw_standby = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] req = 4'h0;
  logic [7:0] rdata;
  logic [3:0] cm_strobe;
  logic [15:0] pattern_pins;
  logic [15:0] pattern_pins_oe;
  int fail_count = 0;
  int n_compared = 0;
  int np_hi, np_lo, te_hi, te_lo, sel, lat_hi, lat_lo, dir_hi, dir_lo;
  // Last entry is unmapped on purpose
  logic [15:0] adr_list [12] = '{ADR_TE_HIGH, ADR_TE_LOW, ADR_TRIG_SEL, ADR_DIR_HIGH,
    ADR_DIR_LOW, ADR_LATCH_HIGH, ADR_LATCH_LOW, ADR_NP_HIGH, ADR_NP_LOW, ADR_NP_HIGH_ALT,
    ADR_NP_LOW_ALT, 16'hFF00};

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  tpo_timed_pattern u_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .hw_standby(hw_standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cm_strobe(cm_strobe), .pattern_pins(pattern_pins), .pattern_pins_oe(pattern_pins_oe));
  tpo_timer_model u_timer (.sys_clk(sys_clk), .resetn(resetn), .req(req),
    .cm_strobe(cm_strobe));

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic model_reset();
    np_hi = 0;
    np_lo = 0;
    te_hi = 0;
    te_lo = 0;
    sel = 255;
    lat_hi = 0;
    lat_lo = 0;
    dir_hi = 0;
    dir_lo = 0;
  endtask

  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    bit sh_hi;
    bit sh_lo;
    sh_hi = sel[7:6] == sel[5:4];
    sh_lo = sel[3:2] == sel[1:0];
    case (a)
      ADR_TE_HIGH: return te_hi[7:0];
      ADR_TE_LOW: return te_lo[7:0];
      ADR_TRIG_SEL: return sel[7:0];
      ADR_DIR_HIGH: return dir_hi[7:0];
      ADR_DIR_LOW: return dir_lo[7:0];
      ADR_LATCH_HIGH: return lat_hi[7:0];
      ADR_LATCH_LOW: return lat_lo[7:0];
      ADR_NP_HIGH: return sh_hi ? np_hi[7:0] : {np_hi[7:4], 4'hF};
      ADR_NP_HIGH_ALT: return sh_hi ? 8'hFF : {4'hF, np_hi[3:0]};
      ADR_NP_LOW: return sh_lo ? np_lo[7:0] : {np_lo[7:4], 4'hF};
      ADR_NP_LOW_ALT: return sh_lo ? 8'hFF : {4'hF, np_lo[3:0]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic mwr(input logic [15:0] a, input int d);
    bit sh_hi;
    bit sh_lo;
    sh_hi = sel[7:6] == sel[5:4];
    sh_lo = sel[3:2] == sel[1:0];
    case (a)
      ADR_TE_HIGH: te_hi = d;
      ADR_TE_LOW: te_lo = d;
      ADR_TRIG_SEL: sel = d;
      ADR_DIR_HIGH: dir_hi = d;
      ADR_DIR_LOW: dir_lo = d;
      ADR_LATCH_HIGH: lat_hi = (lat_hi & te_hi) | (d & ~te_hi & 8'hFF);
      ADR_LATCH_LOW: lat_lo = (lat_lo & te_lo) | (d & ~te_lo & 8'hFF);
      ADR_NP_HIGH: np_hi = sh_hi ? d : (d & 8'hF0) | (np_hi & 8'h0F);
      ADR_NP_LOW: np_lo = sh_lo ? d : (d & 8'hF0) | (np_lo & 8'h0F);
      ADR_NP_HIGH_ALT: if (!sh_hi) np_hi = (np_hi & 8'hF0) | (d & 8'h0F);
      ADR_NP_LOW_ALT: if (!sh_lo) np_lo = (np_lo & 8'hF0) | (d & 8'h0F);
      default: ;
    endcase
  endtask

  task automatic xfer(input int ch);
    int m;
    for (int g = 0; g < 4; g++) begin
      if (((sel >> (2 * g)) & 2'h3) == ch) begin
        m = 4'hF << (4 * (g % 2));
        if (g >= 2) lat_hi = (lat_hi & ~(m & te_hi)) | (np_hi & m & te_hi);
        else lat_lo = (lat_lo & ~(m & te_lo)) | (np_lo & m & te_lo);
      end
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    if (ce) mwr(a, d);
  endtask

  task automatic rd_chk(input logic [15:0] a);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk({8'h00, rdata}, {8'h00, exp_rd(a)});
  endtask

  task automatic rd_all();
    for (int j = 0; j < 12; j++) rd_chk(adr_list[j]);
  endtask

  task automatic pins_chk();
    chk(pattern_pins, {lat_hi[7:0], lat_lo[7:0]});
    chk(pattern_pins_oe, {8'(dir_hi & te_hi), 8'(dir_lo & te_lo)});
  endtask

  // Buffer write in the strobe cycle must not reach the latch yet
  task automatic fire(input int ch, input bit wr_too, input logic [7:0] d);
    @(posedge sys_clk);
    req <= 4'h1 << ch;
    @(posedge sys_clk);
    req <= 4'h0;
    wr <= wr_too;
    addr <= ADR_NP_HIGH;
    wdata <= d;
    @(negedge sys_clk);
    pins_chk();
    @(posedge sys_clk);
    wr <= 1'b0;
    xfer(ch);
    if (wr_too) mwr(ADR_NP_HIGH, d);
    @(negedge sys_clk);
    pins_chk();
  endtask

  initial begin
    logic [7:0] s;
    void'($urandom(27));
    model_reset();
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_all();
    for (int i = 0; i < 32; i++) begin
      s = 8'($urandom);
      if (i % 2 == 0) s = {s[7:6], s[7:6], s[3:2], s[3:2]};
      bus_wr(ADR_TRIG_SEL, s);
      for (int j = 0; j < 12; j++) begin
        if (j != 2) bus_wr(adr_list[j], 8'($urandom));
      end
      rd_all();
      fire(i % 4, i[2], 8'($urandom));
    end
    @(posedge sys_clk);
    hw_standby <= 1'b1;
    @(posedge sys_clk);
    hw_standby <= 1'b0;
    model_reset();
    rd_all();
    pins_chk();
    // Default select must route channel 3 to both high groups
    bus_wr(ADR_TE_HIGH, 8'hFF);
    bus_wr(ADR_NP_HIGH, 8'hA5);
    fire(3, 1'b1, 8'h3C);
    rd_chk(ADR_NP_HIGH);
    @(posedge sys_clk);
    ce <= 1'b0;
    bus_wr(ADR_TE_HIGH, 8'h5A);
    ce <= 1'b1;
    rd_chk(ADR_TE_HIGH);
    bus_wr(ADR_TRIG_SEL, 8'h1B);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    model_reset();
    rd_all();
    pins_chk();
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule
